// ### secp_eeprom.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Input bit taken on serial clock rise
// - Output bit changes on serial clock fall
// - Select high: output off, standby
// - First byte decoded; unknown codes ignored
// - Status write, read, write opcodes decoded
// - Fixed status register bit layout
// - Busy flag high during write cycle
// - Enable command sets, disable clears latch
// - Block protect bits guard array regions
// - Pin protect blocks status writes only
// - Clear latch refuses every write
// - Id select steers access, auto clears
// - Lock makes identification page read-only
// - Select and lock together: no change
// - Sixteen address bits, top ignored
// - Select rise starts write; busy ignores
// - Page write wraps within 64 bytes
// - Latch clears when write cycle ends
// - Status read while busy returns ones
// - Id page uses six address bits
// - Pause: output off, input ignored
// - Write cycle ends within five ms
// - Unknown opcode keeps output off
// - Read address advances and wraps
module secp_eeprom import secp_pkg::*; #(
  parameter int WC_CYCLES = WC_CYCLES_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial pins from the host
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  // Serial output pin, tri-state
  output logic so,
  output logic so_oe
);
  localparam int WCW = $clog2(WC_CYCLES + 1);

  // Synchroniser stages for the five pins
  logic [4:0] s1_r, s2_r;
  logic sck_d_r, cs_d_r;
  logic cs_s, sck_s, si_s, hold_s, wp_s;
  logic rise_ev, fall_ev, cs_rise, cs_fall;

  // Two flops per pin; first stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= 5'h1F;
      s2_r <= 5'h1F;
    end else begin
      s1_r <= {cs_n, sck, si, hold_n, wp_n};
      s2_r <= s1_r;
    end
  end

  assign cs_s = s2_r[4];
  assign sck_s = s2_r[3];
  assign si_s = s2_r[2];
  assign hold_s = s2_r[1];
  assign wp_s = s2_r[0];

  // Delayed copies for edge finding
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
    end
  end

  // Clock edges only count while selected and not paused
  assign rise_ev = sck_s & ~sck_d_r & ~cs_s & hold_s;
  assign fall_ev = ~sck_s & sck_d_r & ~cs_s & hold_s;
  assign cs_rise = cs_s & ~cs_d_r;
  assign cs_fall = ~cs_s & cs_d_r;

  // Engine state
  secp_state_type st_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shin_r, byte_in;
  logic [ADDR_BITS-1:0] addr_r, addr_full, addr_inc, rd_addr;
  logic addr_hi_r, op_rd_r, op_wr_r, got_data_r, sr_got_r;
  logic pend_en_r, pend_dis_r;
  logic [7:0] sr_new_r;
  logic [PAGE_BYTES-1:0] loaded_r;
  logic byte_done;
  // Status bits and write cycle
  logic we_latch_r, busy_r, ppen_r, idsel_r, lock_r;
  logic [1:0] bp_r;
  logic [7:0] status;
  logic [WCW-1:0] wc_cnt_r;
  logic prog_on_r, prog_id_r;
  logic [PAGE_BITS-1:0] prog_idx_r;
  logic [ADDR_BITS-PAGE_BITS-1:0] prog_page_r;
  // Storage; contents are not reset, like real cells
  logic [7:0] mem [0:(1<<ADDR_BITS)-1];
  logic [7:0] id_mem [0:PAGE_BYTES-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [7:0] rd_byte, sh_out_r;
  logic so_r, oe_r;
  logic hw_prot, blk_prot, wr_ok, sr_ok, both_set;

  assign byte_in = {shin_r[6:0], si_s};
  assign byte_done = rise_ev & (bit_cnt_r == 3'h7);
  // Top address bit dropped
  assign addr_full = ADDR_BITS'({addr_r[6:0], byte_in});
  // Id page wraps in six bits, main array in fifteen
  assign addr_inc = idsel_r ?
    {addr_r[ADDR_BITS-1:PAGE_BITS], addr_r[PAGE_BITS-1:0] + 6'h01}
    : addr_r + 15'h0001;
  assign rd_addr = (st_r == ST_ADDR) ? addr_full : addr_inc;
  assign rd_byte = idsel_r ? id_mem[rd_addr[PAGE_BITS-1:0]]
                           : mem[rd_addr];

  // Status image, bit 5 always zero
  assign status = {ppen_r, idsel_r, 1'b0, lock_r, bp_r,
                   we_latch_r, busy_r};

  // Serial command engine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shin_r <= 8'h00;
      addr_r <= '0;
      addr_hi_r <= 1'b0;
      op_rd_r <= 1'b0;
      op_wr_r <= 1'b0;
      got_data_r <= 1'b0;
      sr_got_r <= 1'b0;
      sr_new_r <= SR_RESET;
      pend_en_r <= 1'b0;
      pend_dis_r <= 1'b0;
      loaded_r <= '0;
    end else if (cs_fall) begin
      // New frame: fresh decode
      st_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      addr_hi_r <= 1'b0;
      op_rd_r <= 1'b0;
      op_wr_r <= 1'b0;
      got_data_r <= 1'b0;
      sr_got_r <= 1'b0;
      pend_en_r <= 1'b0;
      pend_dis_r <= 1'b0;
      // Keep loaded map while it is being programmed
      if (!busy_r) begin
        loaded_r <= '0;
      end
    end else if (rise_ev) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shin_r <= byte_in;
      if (bit_cnt_r == 3'h7) begin
        unique case (st_r)
          ST_IDLE: begin
            // Busy: only status reads get through
            if (busy_r && byte_in != OP_STATUS_READ_CMD) begin
              st_r <= ST_IGNORE;
            end else begin
              unique case (byte_in)
                OP_WRITE_ENABLE_CMD: begin
                  pend_en_r <= 1'b1;
                  st_r <= ST_IGNORE;
                end
                OP_WRITE_DISABLE_CMD: begin
                  pend_dis_r <= 1'b1;
                  st_r <= ST_IGNORE;
                end
                OP_STATUS_READ_CMD: st_r <= ST_SRD;
                OP_STATUS_WRITE_CMD: st_r <= ST_SWR;
                OP_MEM_READ: begin
                  op_rd_r <= 1'b1;
                  st_r <= ST_ADDR;
                end
                OP_MEM_WRITE: begin
                  op_wr_r <= 1'b1;
                  st_r <= ST_ADDR;
                end
                default: st_r <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addr_r <= addr_full;
            addr_hi_r <= 1'b1;
            // Always two address bytes
            if (addr_hi_r) begin
              st_r <= op_rd_r ? ST_RDATA : ST_WDATA;
            end
          end
          ST_RDATA: addr_r <= addr_inc;
          ST_WDATA: begin
            // Page fixed, low bits roll over
            addr_r[PAGE_BITS-1:0] <= addr_r[PAGE_BITS-1:0] + 6'h01;
            loaded_r[addr_r[PAGE_BITS-1:0]] <= 1'b1;
            got_data_r <= 1'b1;
          end
          ST_SWR: begin
            sr_new_r <= byte_in;
            sr_got_r <= 1'b1;
            st_r <= ST_IGNORE;
          end
          ST_SRD: st_r <= ST_SRD;
          ST_IGNORE: st_r <= ST_IGNORE;
        endcase
      end
    end
  end

  // Page buffer load; later bytes overwrite on wrap
  always_ff @(posedge mclk) begin
    if (byte_done && st_r == ST_WDATA) begin
      pbuf[addr_r[PAGE_BITS-1:0]] <= byte_in;
    end
  end

  // Output shifter: load on byte end, shift on fall
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_out_r <= SR_BUSY_READ;
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (cs_s) begin
      oe_r <= 1'b0;
    end else if (byte_done) begin
      if ((st_r == ST_IDLE && byte_in == OP_STATUS_READ_CMD) ||
          st_r == ST_SRD) begin
        sh_out_r <= busy_r ? SR_BUSY_READ : status;
      end else if ((st_r == ST_ADDR && addr_hi_r && op_rd_r) ||
                   st_r == ST_RDATA) begin
        sh_out_r <= rd_byte;
      end
    end else if (fall_ev && (st_r == ST_SRD || st_r == ST_RDATA)) begin
      so_r <= sh_out_r[7];
      sh_out_r <= {sh_out_r[6:0], 1'b1};
      oe_r <= 1'b1;
    end
  end

  // Driven only while selected, not paused, answering
  assign so = so_r;
  assign so_oe = oe_r & ~cs_s & hold_s;

  // Protection decode
  assign hw_prot = ~wp_s & ppen_r;
  always_comb begin
    if (idsel_r) begin
      blk_prot = lock_r || bp_r == BP_ALL;
    end else begin
      unique case (bp_r)
        BP_NONE: blk_prot = 1'b0;
        BP_QUARTER: blk_prot = addr_r[14:13] == QUARTER_TOP;
        BP_HALF: blk_prot = addr_r[14];
        BP_ALL: blk_prot = 1'b1;
      endcase
    end
  end

  // Only whole bytes and a set latch start a cycle
  assign wr_ok = cs_rise && st_r == ST_WDATA && got_data_r &&
                 bit_cnt_r == 3'h0 && we_latch_r && !busy_r &&
                 !blk_prot;
  assign sr_ok = cs_rise && sr_got_r && bit_cnt_r == 3'h0 &&
                 we_latch_r && !hw_prot && !busy_r;
  assign both_set = sr_new_r[SR_IDSEL_BIT] & sr_new_r[SR_LOCK_BIT];

  // Status bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      we_latch_r <= 1'b0;
      bp_r <= BP_NONE;
      ppen_r <= 1'b0;
      idsel_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      // Cycle end wins: back to write disabled
      if (busy_r && wc_cnt_r == WCW'(WC_CYCLES - 1)) begin
        we_latch_r <= 1'b0;
      end else if (cs_rise && pend_en_r) begin
        we_latch_r <= 1'b1;
      end else if (cs_rise && pend_dis_r) begin
        we_latch_r <= 1'b0;
      end
      if (sr_ok) begin
        bp_r <= {sr_new_r[SR_BP_HI_BIT], sr_new_r[SR_BP_LO_BIT]};
        ppen_r <= sr_new_r[SR_PPEN_BIT];
        if (!both_set) begin
          idsel_r <= sr_new_r[SR_IDSEL_BIT];
          // Lock is one-way
          lock_r <= lock_r | sr_new_r[SR_LOCK_BIT];
        end
      end else if (cs_rise && addr_hi_r) begin
        idsel_r <= 1'b0;
      end
    end
  end

  // Self-timed write cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      wc_cnt_r <= '0;
    end else if (wr_ok || sr_ok) begin
      busy_r <= 1'b1;
      wc_cnt_r <= '0;
    end else if (busy_r) begin
      wc_cnt_r <= wc_cnt_r + WCW'(1);
      if (wc_cnt_r == WCW'(WC_CYCLES - 1)) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Commit sequencer walks the page, one byte a cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_on_r <= 1'b0;
      prog_id_r <= 1'b0;
      prog_idx_r <= '0;
      prog_page_r <= '0;
    end else if (wr_ok) begin
      prog_on_r <= 1'b1;
      prog_id_r <= idsel_r;
      prog_idx_r <= '0;
      prog_page_r <= addr_r[ADDR_BITS-1:PAGE_BITS];
    end else if (prog_on_r) begin
      prog_idx_r <= prog_idx_r + 6'h01;
      if (prog_idx_r == 6'h3F) begin
        prog_on_r <= 1'b0;
      end
    end
  end

  // Only bytes loaded in this frame reach the cells
  always_ff @(posedge mclk) begin
    if (prog_on_r && loaded_r[prog_idx_r]) begin
      if (prog_id_r) begin
        id_mem[prog_idx_r] <= pbuf[prog_idx_r];
      end else begin
        mem[{prog_page_r, prog_idx_r}] <= pbuf[prog_idx_r];
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_busy_poll;
    byte_done && st_r == ST_IDLE && byte_in == OP_STATUS_READ_CMD && busy_r;
  endsequence
  sequence s_cycle_start;
    wr_ok || sr_ok;
  endsequence
  sequence s_refused;
    cs_rise && !we_latch_r;
  endsequence

  AST_BUSY_READ: assert property (
    s_busy_poll |=> sh_out_r == SR_BUSY_READ)
    else $error("busy status read not all ones");
  AST_SEL_OFF: assert property (cs_s |-> !so_oe)
    else $error("output driven while deselected");
  AST_PAUSE_OFF: assert property (!hold_s |-> !so_oe)
    else $error("output driven during pause");
  AST_SO_ON_FALL: assert property (
    !$stable(so_r) |-> $past(fall_ev))
    else $error("output changed without clock fall");
  AST_REFUSED: assert property (s_refused |=> !busy_r)
    else $error("write started with latch clear");
  AST_START: assert property (
    s_cycle_start |=> busy_r [*2])
    else $error("busy not raised by write");
  AST_LATCH_SET: assert property (
    cs_rise && pend_en_r && !busy_r |=> we_latch_r)
    else $error("enable command did not set latch");
  AST_END_CLEAR: assert property ($fell(busy_r) |-> !we_latch_r)
    else $error("latch still set after cycle");
  AST_BOTH_KEEP: assert property (
    sr_ok && both_set |=> $stable(idsel_r) && $stable(lock_r))
    else $error("select and lock changed together");
  AST_FULL_PROT: assert property (
    cs_rise && st_r == ST_WDATA && bp_r == BP_ALL |=> !busy_r)
    else $error("write into fully protected array");
  AST_WC_BOUND: assert property (
    busy_r |-> wc_cnt_r < WCW'(WC_CYCLES))
    else $error("write cycle overran");
endmodule
`default_nettype wire

// ### secp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module secp_host_model (
  // Pacing clock
  input wire logic mclk,
  // Device output pin
  input wire logic so,
  input wire logic so_oe,
  // Host driven pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic last_so; // Last driven bit
  logic so_line; // Pin level seen by host
  // Released pin shows the inverse, so a stale bit never passes
  assign so_line = so_oe ? so : ~last_so;
  // Track what the device last drove
  always @(posedge mclk) if (so_oe) last_so <= so;
  // Idle pins, clock stands low outside frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    last_so = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Select fall opens a frame
  task automatic open_f();
    tick(1);
    cs_n = 1'b0;
    tick(2);
  endtask
  // Select rise closes it; gap keeps frames apart
  task automatic close_f();
    tick(2);
    cs_n = 1'b1;
    tick(6);
  endtask
  // One byte MSB first, data moves only while sck is low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic oe);
    oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      tick(4);
      rx[i] = so_line;
      oe = oe | so_oe;
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
  endtask
  // Pause with sck low at both edges, select kept low
  task automatic pause(output logic oe);
    tick(2);
    hold_n = 1'b0;
    tick(8);
    oe = so_oe;
    si = ~si;
    tick(2);
    hold_n = 1'b1;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ### secp_pkg.sv
package secp_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  // Status register bit positions
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WE_LATCH_BIT = 1;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_BP_HI_BIT = 3;
  localparam int SR_LOCK_BIT = 4;
  localparam int SR_IDSEL_BIT = 6;
  localparam int SR_PPEN_BIT = 7;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [7:0] SR_BUSY_READ = 8'hFF;
  // Block protect codes and protected region tops
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [1:0] QUARTER_TOP = 2'h3;
  // Array geometry
  localparam int ADDR_BITS = 15;
  localparam int PAGE_BITS = 6;
  localparam int PAGE_BYTES = 64;
  // Timing
  localparam int MCLK_HZ = 20_000_000;
  localparam int WRITE_CYCLE_TIME_MS = 5;
  localparam int WC_CYCLES_DEF = WRITE_CYCLE_TIME_MS * (MCLK_HZ / 1000);
  // Serial engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_RDATA = 7'h04,
    ST_WDATA = 7'h08,
    ST_SRD = 7'h10,
    ST_SWR = 7'h20,
    ST_IGNORE = 7'h40
  } secp_state_type;
endpackage

// ### tb_secp_eeprom.sv
`timescale 1ns/1ps
`default_nettype none
module tb_secp_eeprom import secp_pkg::*;;
  localparam int WC = 400; // Short write cycle keeps the run brief
  logic mclk; // System clock
  logic rst; // Reset
  logic cs_n; // Select from host
  logic sck; // Link clock
  logic si; // Data to device
  logic hold_n; // Pause pin
  logic wp_n; // Protect pin
  logic so; // Data from device
  logic so_oe; // Device drives so
  int n_mismatch; // Mismatches
  int n_tests; // Comparisons
  logic [7:0] r[$]; // Bytes seen in last frame
  logic [7:0] s; // Last status read
  logic [7:0] b; // Scratch byte
  logic oe; // Output enable seen
  logic o; // Scratch enable
  secp_eeprom #(.WC_CYCLES(WC)) dut_u (.mclk(mclk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so), .so_oe(so_oe));
  secp_host_model host_u (.mclk(mclk), .so(so), .so_oe(so_oe),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Whole frame; every byte seen on so is kept
  task automatic frame(input logic [7:0] tx[$]);
    r = {};
    oe = 1'b0;
    host_u.open_f();
    foreach (tx[i]) begin
      host_u.xfer(tx[i], b, o);
      r.push_back(b);
      oe = oe | o;
    end
    host_u.close_f();
  endtask
  task automatic status_read_cmd();
    frame({8'h05, 8'h00});
    s = r[1];
  endtask
  // Poll bounded at five retries after the first read; a hang shows as busy
  task automatic wait_ready();
    int k;
    k = 0;
    status_read_cmd();
    while (s[0] !== 1'b0 && k < 5) begin
      status_read_cmd();
      k++;
    end
    chk({7'h00, s[0]}, 8'h00, "busy end");
  endtask
  task automatic end_test(input string t);
    $display("test %s done", t);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog sized well above the planned traffic
  initial begin
    repeat (80000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk({7'h00, so_oe}, 8'h00, "standby oe");
    status_read_cmd();
    chk(s, SR_RESET, "reset status");
    chk({7'h00, oe}, 8'h01, "status oe");
    frame({8'h06});
    status_read_cmd();
    chk(s, 8'h02, "latch set");
    frame({8'hFF, 8'h00});
    chk({7'h00, oe}, 8'h00, "unknown oe");
    frame({8'h04});
    status_read_cmd();
    chk(s, 8'h00, "latch clear");
    end_test("latch");
    // Pause inside a status read
    host_u.open_f();
    host_u.xfer(8'h05, b, o);
    host_u.pause(o);
    chk({7'h00, o}, 8'h00, "pause oe");
    host_u.xfer(8'h00, b, o);
    host_u.close_f();
    chk(b, 8'h00, "status after pause");
    end_test("pause");
    frame({8'h02, 8'h00, 8'h10, 8'h5A});
    status_read_cmd();
    chk(s, 8'h00, "no cycle when latch clear");
    frame({8'h06});
    frame({8'h02, 8'h80, 8'h10, 8'hA5});
    frame({8'h06});
    status_read_cmd();
    chk(s, SR_BUSY_READ, "busy read");
    wait_ready();
    status_read_cmd();
    chk(s, 8'h00, "latch after cycle");
    frame({8'h03, 8'h00, 8'h10, 8'h00});
    chk(r[3], 8'hA5, "byte write");
    end_test("byte write");
    frame({8'h06});
    frame({8'h02, 8'h00, 8'h3E, 8'h11, 8'h22, 8'h33});
    wait_ready();
    frame({8'h03, 8'h00, 8'h3E, 8'h00, 8'h00});
    chk(r[3], 8'h11, "page byte 3E");
    chk(r[4], 8'h22, "page byte 3F");
    frame({8'h03, 8'hFF, 8'hFF, 8'h00, 8'h00});
    chk(r[4], 8'h33, "wrapped byte");
    end_test("page");
    frame({8'h06});
    frame({8'h01, 8'h04});
    wait_ready();
    status_read_cmd();
    chk(s, 8'h04, "quarter protect");
    frame({8'h06});
    frame({8'h02, 8'h60, 8'h00, 8'h77});
    status_read_cmd();
    chk(s & 8'h01, 8'h00, "protected write refused");
    frame({8'h06});
    frame({8'h02, 8'h5F, 8'hFF, 8'h77});
    wait_ready();
    frame({8'h03, 8'h5F, 8'hFF, 8'h00});
    chk(r[3], 8'h77, "unprotected write");
    frame({8'h06});
    frame({8'h01, 8'h0C});
    wait_ready();
    frame({8'h06});
    frame({8'h02, 8'h00, 8'h00, 8'h99});
    status_read_cmd();
    chk(s, 8'h0E, "full protect refused");
    end_test("block");
    frame({8'h06});
    frame({8'h01, 8'h84});
    wait_ready();
    wp_n = 1'b0;
    frame({8'h06});
    frame({8'h01, 8'h00});
    status_read_cmd();
    chk(s, 8'h86, "status write refused");
    frame({8'h02, 8'h01, 8'h00, 8'h3C});
    status_read_cmd();
    chk(s, SR_BUSY_READ, "open block writable");
    wait_ready();
    wp_n = 1'b1;
    frame({8'h06});
    frame({8'h01, 8'h00});
    wait_ready();
    status_read_cmd();
    chk(s, 8'h00, "protect lifted");
    end_test("pin protect");
    frame({8'h06});
    frame({8'h01, 8'h40});
    wait_ready();
    status_read_cmd();
    chk(s, 8'h40, "id select");
    frame({8'h06});
    frame({8'h02, 8'hFF, 8'hC5, 8'h5A});
    wait_ready();
    status_read_cmd();
    chk(s, 8'h00, "id select cleared");
    frame({8'h06});
    frame({8'h01, 8'h40});
    wait_ready();
    frame({8'h03, 8'h12, 8'h05, 8'h00});
    chk(r[3], 8'h5A, "id page read");
    frame({8'h06});
    frame({8'h01, 8'h50});
    wait_ready();
    status_read_cmd();
    chk(s & 8'h50, 8'h00, "select with lock");
    end_test("id page");
    // Lock the id page, then try to write it
    frame({8'h06});
    frame({8'h01, 8'h10});
    wait_ready();
    status_read_cmd();
    chk(s, 8'h10, "lock set");
    frame({8'h06});
    frame({8'h01, 8'h40});
    wait_ready();
    frame({8'h06});
    frame({8'h02, 8'h00, 8'h05, 8'h00});
    status_read_cmd();
    chk(s, 8'h12, "locked page write refused");
    end_test("lock");
    print_verdict();
  end
endmodule
`default_nettype wire
